// ==== hw/spq_pkg.sv ====
// package: register map, presets, queue sizes and carrier types of the status and error-queue block
package spq_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    // event register sets: operation, questionable, trigger, arm, sequence
    localparam int NUM_SETS = 5;
    localparam int SET_OPER = 0;
    localparam int SET_QUES = 1;
    localparam int SET_TRIG = 2;
    localparam int SET_ARM = 3;
    localparam int SET_SEQ = 4;
    // common registers (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_QUEUE = 8'h04;
    localparam logic [7:0] OFF_QCOUNT = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    // per-set block: base + set * stride, offset within block in the low five bits
    localparam logic [7:0] SET_BASE = 8'h40;
    localparam logic [2:0] SET_FIRST_BLK = 3'h2;
    localparam logic [4:0] OFF_COND = 5'h00;
    localparam logic [4:0] OFF_PTR = 5'h04;
    localparam logic [4:0] OFF_NTR = 5'h08;
    localparam logic [4:0] OFF_EVENT = 5'h0c;
    localparam logic [4:0] OFF_ENABLE = 5'h10;
    // control register fields (write-only strobes)
    localparam int CTRL_PRESET_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    // interrupt status fields
    localparam int IRQ_W = 3;
    localparam int IRQ_MSG_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int IRQ_EVT_BIT = 2;
    // preset and reset values
    localparam logic [15:0] PTR_PRESET = 16'hffff;
    localparam logic [15:0] NTR_PRESET = 16'h0000;
    localparam logic [15:0] EN_CLEAR_VAL = 16'h0000;
    localparam logic [15:0] EN_SET_VAL = 16'hffff;
    localparam logic [4:0] EN_PRESET_ONES = 5'h1c;
    // error queue
    localparam int QUEUE_DEPTH = 10;
    localparam logic [3:0] QUEUE_FULL = 4'ha;
    localparam logic [3:0] QUEUE_LAST = 4'h9;
    localparam logic [15:0] CODE_OVERFLOW = 16'h015e;
    localparam logic [15:0] CODE_NO_ERROR = 16'h0000;

    typedef logic [15:0] spq_word_type;

    // one message offered to the queue by the instrument
    typedef struct packed {
        logic valid;
        logic [15:0] code;
    } spq_msg_type;
endpackage : spq_pkg

// ==== hw/spq_status_queue.sv ====
// status reporting block: event register sets with preset, and the error message queue, on APB
`timescale 1ns/100ps

module spq_status_queue
    import spq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // instrument side
    input wire spq_word_type condIn [NUM_SETS],
    input wire spq_msg_type msgIn,
    // interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic setupPhase; // first cycle of a transfer
    logic accessDone; // transfer completes on this edge
    logic wrDone; // write takes effect
    logic rdDone; // read completes, side effects fire
    logic isSetBlk; // address falls into a set block
    logic [2:0] setIdx; // which set is addressed
    logic [4:0] setOff; // offset inside the set block

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone = accessDone && pwrite;
    assign rdDone = accessDone && !pwrite;
    assign isSetBlk = (paddr >= SET_BASE) && (paddr[7:5] < 3'(int'(SET_FIRST_BLK) + NUM_SETS));
    assign setIdx = paddr[7:5] - SET_FIRST_BLK;
    assign setOff = paddr[4:0];

    // control strobes; both are single-cycle and self-clearing
    logic presetCmd; // status preset command
    logic clearCmd; // clear-status command
    assign presetCmd = wrDone && (paddr == OFF_CTRL) && pwdata[CTRL_PRESET_BIT];
    assign clearCmd = wrDone && (paddr == OFF_CTRL) && pwdata[CTRL_CLEAR_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // event register sets
    spq_word_type ptr_ff [NUM_SETS]; // positive transition filters
    spq_word_type ntr_ff [NUM_SETS]; // negative transition filters
    spq_word_type evt_ff [NUM_SETS]; // sticky event registers
    spq_word_type en_ff [NUM_SETS]; // event enable registers
    spq_word_type condPrev_ff [NUM_SETS]; // last sampled condition, for edges
    spq_word_type evtSet [NUM_SETS]; // bits latched this cycle
    logic [NUM_SETS-1:0] evtHit; // an enabled event was latched

    genvar s;
    generate
        for (s = 0; s < NUM_SETS; s++)
        begin : g_set
            logic selSet; // this set is addressed
            assign selSet = isSetBlk && (setIdx == 3'(s));
            assign evtSet[s] = (condIn[s] & ~condPrev_ff[s] & ptr_ff[s])
                | (~condIn[s] & condPrev_ff[s] & ntr_ff[s]);
            assign evtHit[s] = |(evtSet[s] & en_ff[s]);

            // condition history
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    condPrev_ff[s] <= 16'h0000;
                else
                    condPrev_ff[s] <= condIn[s];
            end

            // filters: preset or software write
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    ptr_ff[s] <= PTR_PRESET;
                    ntr_ff[s] <= NTR_PRESET;
                end
                else if (presetCmd)
                begin
                    ptr_ff[s] <= PTR_PRESET;
                    ntr_ff[s] <= NTR_PRESET;
                end
                else if (wrDone && selSet)
                begin
                    if (setOff == OFF_PTR)
                        ptr_ff[s] <= pwdata[WORD_W-1:0];
                    if (setOff == OFF_NTR)
                        ntr_ff[s] <= pwdata[WORD_W-1:0];
                end
            end

            // enables: preset value depends on the set
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    en_ff[s] <= EN_PRESET_ONES[s] ? EN_SET_VAL : EN_CLEAR_VAL;
                else if (presetCmd)
                    en_ff[s] <= EN_PRESET_ONES[s] ? EN_SET_VAL : EN_CLEAR_VAL;
                else if (wrDone && selSet && (setOff == OFF_ENABLE))
                    en_ff[s] <= pwdata[WORD_W-1:0];
            end

            // events: read clears, a new edge in the same cycle survives; preset has no say here
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    evt_ff[s] <= 16'h0000;
                else if (rdDone && selSet && (setOff == OFF_EVENT))
                    evt_ff[s] <= evtSet[s];
                else
                    evt_ff[s] <= evt_ff[s] | evtSet[s];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // error queue
    spq_word_type qMem_ff [QUEUE_DEPTH]; // message storage
    logic [3:0] rdPtr_ff; // oldest entry
    logic [3:0] wrPtr_ff; // next free entry
    logic [3:0] count_ff; // entries held, 0..10
    logic popArm_ff; // the read captured a real entry in setup
    logic doPop; // remove the oldest entry now
    logic [3:0] effCount; // count once this cycle's pop is gone
    logic doPush; // a message is stored now
    logic [15:0] pushCode; // code actually stored
    logic [3:0] nxt_count; // count after this cycle

    assign doPop = rdDone && (paddr == OFF_QUEUE) && popArm_ff;
    assign effCount = count_ff - 4'(doPop);
    // once full, later messages are dropped; the last slot already tells the host
    assign doPush = msgIn.valid && (effCount < QUEUE_FULL) && !clearCmd;
    assign pushCode = (effCount == QUEUE_LAST) ? CODE_OVERFLOW : msgIn.code;
    assign nxt_count = effCount + 4'(doPush);

    function automatic logic [3:0] wrapInc(input logic [3:0] p);
        wrapInc = (p == QUEUE_LAST) ? 4'h0 : p + 4'h1;
    endfunction : wrapInc

    // pointers and count; clear-status wins over everything, preset is not seen here
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdPtr_ff <= 4'h0;
            wrPtr_ff <= 4'h0;
            count_ff <= 4'h0;
        end
        else if (clearCmd)
        begin
            rdPtr_ff <= 4'h0;
            wrPtr_ff <= 4'h0;
            count_ff <= 4'h0;
        end
        else
        begin
            if (doPop)
                rdPtr_ff <= wrapInc(rdPtr_ff);
            if (doPush)
                wrPtr_ff <= wrapInc(wrPtr_ff);
            count_ff <= nxt_count;
        end
    end

    // storage; no reset needed, count guards every read
    always_ff @(posedge core_clk)
    begin
        if (doPush)
            qMem_ff[wrPtr_ff] <= pushCode;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    logic [IRQ_W-1:0] irqStat_ff; // sticky, write one to clear
    logic [IRQ_W-1:0] irqMask_ff; // one lets the bit reach irq
    logic [IRQ_W-1:0] irqEvt; // events this cycle

    assign irqEvt = {|evtHit, doPush && (pushCode == CODE_OVERFLOW), doPush};

    // a new event beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            irqStat_ff <= '0;
        else if (wrDone && (paddr == OFF_IRQ_STAT))
            irqStat_ff <= (irqStat_ff & ~pwdata[IRQ_W-1:0]) | irqEvt;
        else
            irqStat_ff <= irqStat_ff | irqEvt;
    end

    // mask register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            irqMask_ff <= '0;
        else if (wrDone && (paddr == OFF_IRQ_MASK))
            irqMask_ff <= pwdata[IRQ_W-1:0];
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |(irqStat_ff & irqMask_ff);
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, evaluated during setup so data stands through the access
    logic [DATA_W-1:0] rdData; // word for the addressed register
    logic rdErr; // address not mapped

    always_comb
    begin
        rdData = '0;
        rdErr = 1'b0;
        if (isSetBlk)
        begin
            case (setOff)
                OFF_COND: rdData = {16'h0000, condIn[setIdx]};
                OFF_PTR: rdData = {16'h0000, ptr_ff[setIdx]};
                OFF_NTR: rdData = {16'h0000, ntr_ff[setIdx]};
                OFF_EVENT: rdData = {16'h0000, evt_ff[setIdx]};
                OFF_ENABLE: rdData = {16'h0000, en_ff[setIdx]};
                default: rdErr = 1'b1;
            endcase
        end
        else
        begin
            case (paddr)
                OFF_CTRL: rdData = '0; // strobes read as zero
                OFF_QUEUE: rdData = (count_ff == 4'h0) ? {16'h0000, CODE_NO_ERROR}
                    : {{16{qMem_ff[rdPtr_ff][15]}}, qMem_ff[rdPtr_ff]};
                OFF_QCOUNT: rdData = {28'h0000000, count_ff};
                OFF_IRQ_STAT: rdData = {29'h00000000, irqStat_ff};
                OFF_IRQ_MASK: rdData = {29'h00000000, irqMask_ff};
                default: rdErr = 1'b1;
            endcase
        end
    end

    // apb answer: zero wait states, captured at setup
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
            popArm_ff <= 1'b0;
        end
        else if (setupPhase)
        begin
            prdata <= pwrite ? '0 : rdData;
            pslverr <= rdErr;
            popArm_ff <= !pwrite && (paddr == OFF_QUEUE) && (count_ff != 4'h0);
        end
    end

    // ready sits high from the first edge after reset
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            pready <= 1'b0;
        else
            pready <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic [3:0] lastIdx; // slot written last
    assign lastIdx = (wrPtr_ff == 4'h0) ? QUEUE_LAST : wrPtr_ff - 4'h1;

    chk_preset_ptr: assert property (presetCmd |=> ptr_ff[SET_ARM] == PTR_PRESET)
        else $error("positive filter not loaded by preset");
    chk_preset_ntr: assert property (presetCmd |=> ntr_ff[SET_QUES] == NTR_PRESET)
        else $error("negative filter not cleared by preset");
    chk_preset_en_low: assert property (presetCmd |=> (en_ff[SET_OPER] | en_ff[SET_QUES]) == 16'h0000)
        else $error("operation or questionable enable not cleared");
    chk_preset_en_high: assert property (presetCmd |=> (en_ff[SET_TRIG] & en_ff[SET_ARM] & en_ff[SET_SEQ])
        == 16'hffff)
        else $error("trigger arm or sequence enable not set");
    chk_preset_keeps_evt: assert property (presetCmd && evtSet[SET_OPER] == 16'h0000
        |=> evt_ff[SET_OPER] == $past(evt_ff[SET_OPER]))
        else $error("preset disturbed an event register");
    chk_cond_readback: assert property (setupPhase && !pwrite && paddr == SET_BASE
        |=> prdata == {16'h0000, $past(condIn[SET_OPER])})
        else $error("condition read not live value");
    chk_push_grows: assert property (msgIn.valid && count_ff < QUEUE_LAST && !doPop && !clearCmd
        |=> count_ff == $past(count_ff) + 4'h1)
        else $error("message not appended");
    chk_clear_empties: assert property (clearCmd |=> count_ff == 4'h0)
        else $error("clear-status left messages");
    chk_preset_keeps_q: assert property (presetCmd && !clearCmd && !msgIn.valid && !doPop
        |=> $stable(count_ff))
        else $error("preset changed the queue");
    chk_pop_oldest: assert property (doPop && !msgIn.valid |=> count_ff == $past(count_ff) - 4'h1)
        else $error("queue read did not remove entry");
    chk_full_overflow: assert property (count_ff == QUEUE_FULL |-> qMem_ff[lastIdx] == CODE_OVERFLOW)
        else $error("last slot of full queue not overflow");
    chk_empty_noerr: assert property (setupPhase && !pwrite && paddr == OFF_QUEUE && count_ff == 4'h0
        |=> prdata == 32'h00000000 && !doPop)
        else $error("empty queue read not no-error");

    cov_preset: cover property (presetCmd);
    cov_queue_full: cover property (count_ff == QUEUE_FULL);
    cov_pop_push: cover property (doPop && doPush);
    cov_irq: cover property (irq);
endmodule : spq_status_queue

// ==== bench/spq_host_side.sv ====
// host-side partner: drives live condition words and pulses instrument messages
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module spq_host_side
    import spq_pkg::*;
(
    // clock
    input wire logic core_clk,
    // instrument-side drive
    output spq_msg_type msgOut,
    output spq_word_type condOut [NUM_SETS]
);
    // quiet start: no message pending, conditions all low
    initial
    begin
        msgOut = '0;
        foreach (condOut[i]) condOut[i] = '0;
    end

    // one-cycle message pulse; the idle code is inverted so a stale code never looks valid
    task automatic sendMsg(input spq_word_type code);
        @(posedge core_clk);
        msgOut <= '{valid: 1'b1, code: code};
        @(posedge core_clk);
        msgOut <= '{valid: 1'b0, code: ~code};
    endtask : sendMsg

    // live condition word of one set, changed right after an edge
    task automatic setCond(input int s, input spq_word_type w);
        @(posedge core_clk);
        condOut[s] <= w;
    endtask : setCond
endmodule : spq_host_side

// ==== bench/spq_status_queue_test.sv ====
// self-checking testbench of the status and error-queue block
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module spq_status_queue_test
    import spq_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, irq;
    spq_msg_type msgIn;
    spq_word_type condIn [NUM_SETS];
    // model state: queue of codes, filters and enables per set
    spq_word_type modelQ[$];
    spq_word_type ptrM [NUM_SETS], ntrM [NUM_SETS], enM [NUM_SETS], condM [NUM_SETS];
    spq_word_type w;
    logic [31:0] rd;
    logic err;
    int seed = 3575;
    int fails = 0, checkCount = 0, cycles = 0;

    spq_status_queue i_spq_status_queue (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .condIn(condIn), .msgIn(msgIn), .irq(irq));
    spq_host_side i_spq_host_side (.core_clk(core_clk), .msgOut(msgIn), .condOut(condIn));

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard: the whole run needs well under this many cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkBit(input logic got, input logic exp);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkBit

    // apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chkBit(err, 1'b0);
    endtask : rdChk

    function automatic logic [7:0] setAddr(input int s, input logic [4:0] off);
        return SET_BASE + 8'(s * 32) + {3'h0, off};
    endfunction : setAddr

    // model append: the tenth slot holds the overflow code, later ones are lost
    function automatic void pushModel(input spq_word_type c);
        if (modelQ.size() < 9) modelQ.push_back(c);
        else if (modelQ.size() == 9) modelQ.push_back(16'h015e);
    endfunction : pushModel

    // model read: oldest entry sign-extended, or the no-error code when empty
    function automatic logic [31:0] popModel();
        spq_word_type c;
        if (modelQ.size() == 0) return 32'h0;
        c = modelQ.pop_front();
        return {{16{c[15]}}, c};
    endfunction : popModel
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        // power-up state
        rdChk(OFF_QCOUNT, 32'h0);
        rdChk(OFF_QUEUE, 32'h0);
        $display("test reset done");
        // random filters and enables, then preset
        for (int s = 0; s < NUM_SETS; s++)
        begin
            ptrM[s] = 16'($random(seed));
            ntrM[s] = 16'($random(seed));
            enM[s] = 16'($random(seed));
            apb(1'b1, setAddr(s, OFF_PTR), {16'h0, ptrM[s]});
            apb(1'b1, setAddr(s, OFF_NTR), {16'h0, ntrM[s]});
            apb(1'b1, setAddr(s, OFF_ENABLE), {16'h0, enM[s]});
            rdChk(setAddr(s, OFF_PTR), {16'h0, ptrM[s]});
            rdChk(setAddr(s, OFF_NTR), {16'h0, ntrM[s]});
            rdChk(setAddr(s, OFF_ENABLE), {16'h0, enM[s]});
        end
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h1);
        for (int s = 0; s < NUM_SETS; s++)
        begin
            rdChk(setAddr(s, OFF_PTR), 32'h0000ffff);
            rdChk(setAddr(s, OFF_NTR), 32'h0);
            rdChk(setAddr(s, OFF_ENABLE), (s >= SET_TRIG) ? 32'h0000ffff : 32'h0);
            rdChk(setAddr(s, OFF_EVENT), 32'h0);
        end
        rdChk(OFF_IRQ_MASK, 32'h1);
        $display("test preset done");
        // live condition words; rising bits latch events through the all-ones positive filters
        for (int s = 0; s < NUM_SETS; s++)
        begin
            condM[s] = 16'($random(seed));
            i_spq_host_side.setCond(s, condM[s]);
            rdChk(setAddr(s, OFF_COND), {16'h0, condM[s]});
        end
        // a second preset must leave the latched events alone
        apb(1'b1, OFF_CTRL, 32'h1);
        for (int s = 0; s < NUM_SETS; s++)
        begin
            rdChk(setAddr(s, OFF_EVENT), {16'h0, condM[s]});
        end
        $display("test condition done");
        // twelve messages: fill, overflow, drop, then drain past empty
        for (int i = 0; i < 12; i++)
        begin
            w = 16'($random(seed));
            i_spq_host_side.sendMsg(w);
            pushModel(w);
        end
        repeat (3) @(posedge core_clk);
        chkBit(irq, 1'b1);
        rdChk(OFF_QCOUNT, 32'd10);
        // event bit comes from the trigger, arm and sequence sets, whose enables are all ones
        rdChk(OFF_IRQ_STAT, {29'h0, |(condM[SET_TRIG] | condM[SET_ARM] | condM[SET_SEQ]), 2'b11});
        for (int i = 0; i < 11; i++) rdChk(OFF_QUEUE, popModel());
        apb(1'b1, OFF_IRQ_STAT, 32'h7);
        repeat (3) @(posedge core_clk);
        chkBit(irq, 1'b0);
        rdChk(OFF_IRQ_STAT, 32'h0);
        $display("test queue done");
        // preset keeps the queue, clear-status empties it
        for (int i = 0; i < 3; i++)
        begin
            w = 16'($random(seed));
            i_spq_host_side.sendMsg(w);
            pushModel(w);
        end
        apb(1'b1, OFF_CTRL, 32'h1);
        rdChk(OFF_QCOUNT, 32'd3);
        rdChk(OFF_QUEUE, popModel());
        apb(1'b1, OFF_CTRL, 32'h2);
        modelQ.delete();
        rdChk(OFF_QCOUNT, 32'h0);
        rdChk(OFF_QUEUE, popModel());
        $display("test clear done");
        // unmapped places answer with an error and zero data
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        chkBit(err, 1'b1);
        apb(1'b1, setAddr(0, 5'h14), 32'h1234);
        chkBit(err, 1'b1);
        $display("test unmapped done");
        conclude();
    end
endmodule : spq_status_queue_test
